// File: rtl/dual_port_mailbox_ram.sv
// Two-port shared RAM with select decode, byte lanes, output enable and mailbox flags.
// Assumes both host ports run on clk; only the master init pin and the output enables are asynchronous.
//
// What this block does
// R01: A port accesses the array only while its low-active select is held low.
// R02: A port accesses the array only while its high-active select is also held high.
// R03: The direction input low requests a write and high requests a read.
// R04: Only the byte lanes whose enable is set are written or read back.
// R05: Data pins are driven during a read only while the output enable is held low.
// R06: The two highest addresses are the mailboxes, one for each port.
// R07: A write by one port to the other port's mailbox pulls the other port's flag low.
// R08: A read by a port of its own mailbox returns that port's flag high.
// R09: The address width is a parameter from 15 to 19 bits.
// R10: Master init forces both mailbox flags and both counter flags high.
// R11: Each port samples its controls other than the output enable, and its address, on the rising edge of its clock.
`timescale 1ns/1ns
`default_nettype none
module dual_port_mailbox_ram
    import dual_port_mailbox_pkg::*;
#(
    // R09 depth-dependent address width
    parameter int ADDR_WIDTH = ADDR_WIDTH_MAX
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Master init pin, asynchronous to clk
    input wire logic master_init_n,
    // Left port controls
    input wire logic left_select_low_active_n,
    input wire logic left_select_high_active,
    input wire logic left_read_write_n,
    input wire logic [LANE_COUNT-1:0] left_byte_lane_enable,
    input wire logic [ADDR_WIDTH-1:0] left_addr,
    input wire logic left_out_enable_n,
    // Left port data pins
    input wire logic [DATA_WIDTH-1:0] left_dq_in,
    output logic [DATA_WIDTH-1:0] left_dq_out,
    output logic left_dq_oe_n,
    // Left port flags
    output logic left_mailbox_flag_n,
    output logic left_counter_wrap_flag_n,
    // Right port controls
    input wire logic right_select_low_active_n,
    input wire logic right_select_high_active,
    input wire logic right_read_write_n,
    input wire logic [LANE_COUNT-1:0] right_byte_lane_enable,
    input wire logic [ADDR_WIDTH-1:0] right_addr,
    input wire logic right_out_enable_n,
    // Right port data pins
    input wire logic [DATA_WIDTH-1:0] right_dq_in,
    output logic [DATA_WIDTH-1:0] right_dq_out,
    output logic right_dq_oe_n,
    // Right port flags
    output logic right_mailbox_flag_n,
    output logic right_counter_wrap_flag_n
);
    localparam logic [ADDR_WIDTH-1:0] TOP_ADDR = {ADDR_WIDTH{1'b1}};
    // R06 mailbox locations
    localparam logic [ADDR_WIDTH-1:0] LEFT_MAILBOX =
        TOP_ADDR - ADDR_WIDTH'(LEFT_MAILBOX_FROM_TOP);
    localparam logic [ADDR_WIDTH-1:0] RIGHT_MAILBOX =
        TOP_ADDR - ADDR_WIDTH'(RIGHT_MAILBOX_FROM_TOP);
    localparam logic [PORT_COUNT-1:0][ADDR_WIDTH-1:0] OWN_MAILBOX =
        {RIGHT_MAILBOX, LEFT_MAILBOX};

    // Port-indexed views of the separate pins.
    logic [PORT_COUNT-1:0] sel_low_n;
    logic [PORT_COUNT-1:0] sel_high;
    logic [PORT_COUNT-1:0] rw_n;
    logic [PORT_COUNT-1:0] oe_n;
    logic [PORT_COUNT-1:0][LANE_COUNT-1:0] lanes;
    logic [PORT_COUNT-1:0][ADDR_WIDTH-1:0] addr;
    logic [PORT_COUNT-1:0][DATA_WIDTH-1:0] wdata;
    logic [PORT_COUNT-1:0][DATA_WIDTH-1:0] rdata;
    logic [PORT_COUNT-1:0] access;
    logic [PORT_COUNT-1:0] write;
    logic [PORT_COUNT-1:0] read;

    // Read-pending and mailbox state.
    logic [PORT_COUNT-1:0] read_valid;
    logic [PORT_COUNT-1:0] next_read_valid;
    logic [PORT_COUNT-1:0] pending;
    logic [PORT_COUNT-1:0] next_pending;

    // Master init synchroniser and counter flag state.
    logic init_meta_n;
    logic init_sync_n;
    logic [PORT_COUNT-1:0] wrap_flag_n;
    logic [PORT_COUNT-1:0] next_wrap_flag_n;

    assign sel_low_n = {right_select_low_active_n, left_select_low_active_n};
    assign sel_high = {right_select_high_active, left_select_high_active};
    assign rw_n = {right_read_write_n, left_read_write_n};
    assign oe_n = {right_out_enable_n, left_out_enable_n};
    assign lanes = {right_byte_lane_enable, left_byte_lane_enable};
    assign addr = {right_addr, left_addr};
    assign wdata = {right_dq_in, left_dq_in};

    ////////////////////////////////////////////////////////////////////////////
    // Access decode; all controls but out_enable_n are taken on the rising edge of clk.
    // Both selects must agree in the same cycle; a half-selected port is simply idle.
    always_comb begin
        for (int p = 0; p < PORT_COUNT; p++) begin
            // R01 low-active select gate
            // R02 high-active select gate
            access[p] = !sel_low_n[p] && sel_high[p];
            // R03 direction decode
            write[p] = access[p] && !rw_n[p];
            read[p] = access[p] && rw_n[p];
        end
    end

    // R04 lane-masked storage
    // R11 sampling on the clock edge
    dual_port_array #(
        .ADDR_WIDTH(ADDR_WIDTH)
    ) u_array (
        .clk(clk),
        .write(write),
        .read(read),
        .addr(addr),
        .lanes(lanes),
        .wdata(wdata),
        .rdata(rdata)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Read data are held on the pins until the next access of that port.
    // A read taken while out_enable_n is high still loads the read register, so the
    // host can open the pins later and see that word without a second access.
    always_comb begin
        next_read_valid = read_valid;
        for (int p = 0; p < PORT_COUNT; p++) begin
            if (access[p]) begin
                next_read_valid[p] = read[p];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            read_valid <= '0;
        end else begin
            read_valid <= next_read_valid;
        end
    end

    assign left_dq_out = rdata[LEFT];
    assign right_dq_out = rdata[RIGHT];
    // R05 asynchronous output enable
    assign left_dq_oe_n = !(read_valid[LEFT] && !oe_n[LEFT]);
    assign right_dq_oe_n = !(read_valid[RIGHT] && !oe_n[RIGHT]);

    ////////////////////////////////////////////////////////////////////////////
    // Master init is a pin, so it is brought onto clk before anything reads it.
    // Its reset value is the inactive level, so leaving rst does not look like an init.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            init_meta_n <= SYNC_RESET;
            init_sync_n <= SYNC_RESET;
        end else begin
            init_meta_n <= master_init_n;
            init_sync_n <= init_meta_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mailbox address match, shared by the set and the clear paths.
    function automatic logic hits_mailbox(
        input logic [ADDR_WIDTH-1:0] word,
        input int owner
    );
        return word == OWN_MAILBOX[owner];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Mailbox flags. A message arriving in the same cycle as the owner's read
    // keeps the flag asserted, so no message is lost.
    always_comb begin
        next_pending = pending;
        for (int p = 0; p < PORT_COUNT; p++) begin
            // R08 own mailbox read clears
            if (read[p] && hits_mailbox(addr[p], p)) begin
                next_pending[p] = 1'b0;
            end
            // R07 far mailbox write asserts
            if (write[1-p] && hits_mailbox(addr[1-p], p)) begin
                next_pending[p] = 1'b1;
            end
        end
        // R10 master init forces inactive
        if (!init_sync_n) begin
            next_pending = {PORT_COUNT{FLAG_RESET}};
        end
    end

    // The counter is outside this block, so its flags only see master init.
    // Keeping them as registers lets a later counter drive them without new reset paths.
    always_comb begin
        next_wrap_flag_n = wrap_flag_n;
        // R10 counter flags inactive
        if (!init_sync_n) begin
            next_wrap_flag_n = '1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pending <= {PORT_COUNT{FLAG_RESET}};
            wrap_flag_n <= '1;
        end else begin
            pending <= next_pending;
            wrap_flag_n <= next_wrap_flag_n;
        end
    end

    assign left_mailbox_flag_n = !pending[LEFT];
    assign right_mailbox_flag_n = !pending[RIGHT];
    assign left_counter_wrap_flag_n = wrap_flag_n[LEFT];
    assign right_counter_wrap_flag_n = wrap_flag_n[RIGHT];
endmodule // dual_port_mailbox_ram
`default_nettype wire

// File: rtl/dual_port_mailbox_pkg.sv
// Constants shared by the dual-port mailbox RAM and its storage array.
// Assumes one system clock drives both port front ends.
package dual_port_mailbox_pkg;
    // Word layout: four byte lanes of nine bits each.
    localparam int DATA_WIDTH = 36;
    localparam int LANE_COUNT = 4;
    localparam int LANE_WIDTH = 9;
    // Address width of the largest family member; 15 is the smallest.
    localparam int ADDR_WIDTH_MAX = 19;
    localparam int ADDR_WIDTH_MIN = 15;
    // Mailbox offsets counted down from the top of the array.
    localparam int LEFT_MAILBOX_FROM_TOP = 0;
    localparam int RIGHT_MAILBOX_FROM_TOP = 1;
    // Port indices.
    localparam int LEFT = 0;
    localparam int RIGHT = 1;
    localparam int PORT_COUNT = 2;
    // Reset values of the pending flags and of the synchroniser stages.
    localparam logic FLAG_RESET = 1'b0;
    localparam logic SYNC_RESET = 1'b1;
endpackage

// File: rtl/dual_port_array.sv
// True dual-port storage with per-lane write and read enables.
// Assumes the caller resolves collisions; two writes to one word are undefined.
`timescale 1ns/1ns
`default_nettype none
module dual_port_array
    import dual_port_mailbox_pkg::*;
#(
    parameter int ADDR_WIDTH = ADDR_WIDTH_MAX
) (
    // Clock
    input wire logic clk,
    // Port requests
    input wire logic [PORT_COUNT-1:0] write,
    input wire logic [PORT_COUNT-1:0] read,
    input wire logic [PORT_COUNT-1:0][ADDR_WIDTH-1:0] addr,
    input wire logic [PORT_COUNT-1:0][LANE_COUNT-1:0] lanes,
    input wire logic [PORT_COUNT-1:0][DATA_WIDTH-1:0] wdata,
    // Registered read data, disabled lanes read as zero
    output logic [PORT_COUNT-1:0][DATA_WIDTH-1:0] rdata
);
    logic [DATA_WIDTH-1:0] mem [0:(1<<ADDR_WIDTH)-1];

    ////////////////////////////////////////////////////////////////////////////
    // One process writes the array, so every word has a single driver; when both
    // ports write one word in a cycle the right port wins, which is harmless
    // because that case is undefined for the hosts.
    always_ff @(posedge clk) begin
        for (int p = 0; p < PORT_COUNT; p++) begin
            for (int l = 0; l < LANE_COUNT; l++) begin
                if (write[p] && lanes[p][l]) begin
                    mem[addr[p]][l*LANE_WIDTH +: LANE_WIDTH] <=
                        wdata[p][l*LANE_WIDTH +: LANE_WIDTH];
                end
            end
        end
    end

    // Read registers, one per port and lane.
    for (genvar p = 0; p < PORT_COUNT; p++) begin : g_port
        for (genvar l = 0; l < LANE_COUNT; l++) begin : g_lane
            always_ff @(posedge clk) begin
                if (read[p]) begin
                    rdata[p][l*LANE_WIDTH +: LANE_WIDTH] <= lanes[p][l]
                        ? mem[addr[p]][l*LANE_WIDTH +: LANE_WIDTH]
                        : {LANE_WIDTH{1'b0}};
                end
            end
        end
    end
endmodule // dual_port_array
`default_nettype wire

// File: dv/mbox_checker.sv
// Port assertions for the mailbox RAM.
// Bound into every dual_port_mailbox_ram; sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module mbox_checker
    import dual_port_mailbox_pkg::*;
#(
    parameter int ADDR_WIDTH = ADDR_WIDTH_MAX
) (
    // Clock, reset and master init
    input wire logic clk,
    input wire logic rst,
    input wire logic master_init_n,
    // Left port controls
    input wire logic left_select_low_active_n,
    input wire logic left_select_high_active,
    input wire logic left_read_write_n,
    input wire logic [ADDR_WIDTH-1:0] left_addr,
    input wire logic left_out_enable_n,
    input wire logic left_dq_oe_n,
    // Right port controls
    input wire logic right_select_low_active_n,
    input wire logic right_select_high_active,
    input wire logic right_read_write_n,
    input wire logic [ADDR_WIDTH-1:0] right_addr,
    input wire logic right_out_enable_n,
    input wire logic right_dq_oe_n,
    // Flags
    input wire logic left_mailbox_flag_n,
    input wire logic right_mailbox_flag_n,
    input wire logic left_counter_wrap_flag_n,
    input wire logic right_counter_wrap_flag_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire logic [ADDR_WIDTH-1:0] top = '1;
    wire logic lsel = !left_select_low_active_n && left_select_high_active;
    wire logic rsel = !right_select_low_active_n && right_select_high_active;
    wire logic rw_top = rsel && !right_read_write_n && right_addr == top;
    wire logic lw_box = lsel && !left_read_write_n && left_addr == top - 1'b1;
    wire logic lr_top = lsel && left_read_write_n && left_addr == top;
    AST_LOE: assert property (left_out_enable_n |-> left_dq_oe_n)
        else $error("left pins driven without enable");
    AST_ROE: assert property (right_out_enable_n |-> right_dq_oe_n)
        else $error("right pins driven without enable");
    AST_WEND: assert property (lsel && !left_read_write_n |=> left_dq_oe_n)
        else $error("left pins driven after a write");
    // Master init reaches the flags two edges late, so a write is judged only when
    // init was idle two samples earlier.
    AST_LSET: assert property (rw_top && $past(master_init_n, 2) |=> !left_mailbox_flag_n)
        else $error("left flag not raised");
    AST_RSET: assert property (lw_box && $past(master_init_n, 2) |=> !right_mailbox_flag_n)
        else $error("right flag not raised");
    AST_LCLR: assert property (lr_top && !rw_top |=> left_mailbox_flag_n)
        else $error("left flag not cleared");
    AST_CW: assert property (left_counter_wrap_flag_n && right_counter_wrap_flag_n)
        else $error("counter flag low");
    AST_INIT: assert property (
        !master_init_n [*4] |-> left_mailbox_flag_n && right_mailbox_flag_n)
        else $error("init left a flag low");
endmodule // mbox_checker
bind dual_port_mailbox_ram mbox_checker #(.ADDR_WIDTH(ADDR_WIDTH)) mbox_checker_i (.*);
`default_nettype wire

// File: dv/port_host.sv
// Behavioural host for one port of the mailbox RAM.
// Callers enter access just after a rising clock edge.
`timescale 1ns/1ns
`default_nettype none
module port_host
    import dual_port_mailbox_pkg::*;
#(
    parameter int AW = ADDR_WIDTH_MIN
) (
    // Clock
    input wire logic clk,
    // Port controls
    output logic sel_n,
    output logic sel_hi,
    output logic rw_n,
    output logic [LANE_COUNT-1:0] lanes,
    output logic [AW-1:0] addr,
    output logic oe_n,
    output logic [DATA_WIDTH-1:0] wdata,
    // Pins as the board sees them
    input wire logic [DATA_WIDTH-1:0] dq_out,
    input wire logic dq_oe_n,
    output logic [DATA_WIDTH-1:0] bus
);
    logic [DATA_WIDTH-1:0] last = '0;
    initial begin
        sel_n = 1'h1;
        sel_hi = 1'h0;
        rw_n = 1'h1;
        lanes = '0;
        addr = '0;
        oe_n = 1'h0;
        wdata = '0;
    end
    assign bus = dq_oe_n ? ~last : dq_out;
    always @(posedge clk) if (!dq_oe_n) last <= dq_out;
    task automatic access(input logic sn, sh, w, input logic [AW-1:0] a,
            input logic [LANE_COUNT-1:0] l, input logic [DATA_WIDTH-1:0] d);
        sel_n = sn;
        sel_hi = sh;
        rw_n = !w;
        addr = a;
        lanes = l;
        wdata = d;
        @(posedge clk);
        #1;
        sel_n = 1'h1;
        sel_hi = 1'h0;
        // One idle edge, so a following call never re-drives a select in this step.
        @(posedge clk);
        #1;
    endtask
endmodule // port_host
`default_nettype wire

// File: dv/test_dual_port_mailbox_ram.sv
// Self-checking bench: a host on each port of the mailbox RAM.
// Needs the package, the design, port_host and the checker.
`timescale 1ns/1ns
`default_nettype none
module test_dual_port_mailbox_ram import dual_port_mailbox_pkg::*;;
    localparam int AW = ADDR_WIDTH_MIN;
    localparam logic [AW-1:0] TOP = '1;
    logic clk, rst, master_init_n;
    logic l_sn, l_sh, l_rw, l_oe, l_doe, l_mb, l_cw, r_sn, r_sh, r_rw, r_oe, r_doe, r_mb, r_cw;
    logic [LANE_COUNT-1:0] l_be, r_be;
    logic [AW-1:0] l_a, r_a;
    logic [DATA_WIDTH-1:0] l_wd, r_wd, l_do, r_do, l_bus, r_bus, w;
    int mismatches = 0;
    int total_checks = 0;
    dual_port_mailbox_ram #(.ADDR_WIDTH(AW)) dual_port_mailbox_ram_i (
        .clk(clk), .rst(rst), .master_init_n(master_init_n),
        .left_select_low_active_n(l_sn), .left_select_high_active(l_sh),
        .left_read_write_n(l_rw), .left_byte_lane_enable(l_be), .left_addr(l_a),
        .left_out_enable_n(l_oe), .left_dq_in(l_wd), .left_dq_out(l_do), .left_dq_oe_n(l_doe),
        .left_mailbox_flag_n(l_mb), .left_counter_wrap_flag_n(l_cw),
        .right_select_low_active_n(r_sn), .right_select_high_active(r_sh),
        .right_read_write_n(r_rw), .right_byte_lane_enable(r_be), .right_addr(r_a),
        .right_out_enable_n(r_oe), .right_dq_in(r_wd), .right_dq_out(r_do),
        .right_dq_oe_n(r_doe), .right_mailbox_flag_n(r_mb), .right_counter_wrap_flag_n(r_cw));
    port_host #(.AW(AW)) port_host_l_i (.clk(clk), .sel_n(l_sn), .sel_hi(l_sh), .rw_n(l_rw),
        .lanes(l_be), .addr(l_a), .oe_n(l_oe), .wdata(l_wd), .dq_out(l_do), .dq_oe_n(l_doe),
        .bus(l_bus));
    port_host #(.AW(AW)) port_host_r_i (.clk(clk), .sel_n(r_sn), .sel_hi(r_sh), .rw_n(r_rw),
        .lanes(r_be), .addr(r_a), .oe_n(r_oe), .wdata(r_wd), .dq_out(r_do), .dq_oe_n(r_doe),
        .bus(r_bus));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [DATA_WIDTH-1:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    function automatic logic [DATA_WIDTH-1:0] lm(input logic [LANE_COUNT-1:0] l);
        for (int i = 0; i < LANE_COUNT; i++) lm[i*LANE_WIDTH +: LANE_WIDTH] = {LANE_WIDTH{l[i]}};
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_lanes();
        w = (36'h123456789 & ~lm(4'h5)) | (36'h9ABCDEF01 & lm(4'h5));
        port_host_l_i.access(1'h0, 1'h1, 1'h1, 15'h0010, 4'hF, 36'h123456789);
        port_host_l_i.access(1'h0, 1'h1, 1'h1, 15'h0010, 4'h5, 36'h9ABCDEF01);
        port_host_l_i.access(1'h0, 1'h1, 1'h0, 15'h0010, 4'hF, '0);
        check(l_bus, w);
        port_host_l_i.access(1'h0, 1'h1, 1'h0, 15'h0010, 4'hA, '0);
        check(l_bus, w & lm(4'hA));
        port_host_r_i.access(1'h1, 1'h1, 1'h1, 15'h0010, 4'hF, '0);
        port_host_r_i.access(1'h0, 1'h0, 1'h1, 15'h0010, 4'hF, '0);
        port_host_r_i.access(1'h0, 1'h1, 1'h0, 15'h0010, 4'hF, '0);
        check(r_bus, w);
        port_host_l_i.oe_n = 1'h1;
        port_host_l_i.access(1'h0, 1'h1, 1'h0, 15'h0010, 4'hF, '0);
        check(36'(l_doe), 36'h1);
        port_host_l_i.oe_n = 1'h0;
        #1;
        check(l_bus, w);
    endtask
    task automatic t_mail();
        port_host_r_i.access(1'h0, 1'h1, 1'h1, TOP, 4'hF, 36'h0000000A5);
        check(36'(l_mb), 36'h0);
        port_host_l_i.access(1'h0, 1'h1, 1'h1, TOP - 15'h1, 4'hF, 36'h5A5A5A5A5);
        port_host_l_i.access(1'h0, 1'h1, 1'h0, TOP - 15'h1, 4'hF, '0);
        check(36'(r_mb), 36'h0);
        port_host_l_i.access(1'h0, 1'h1, 1'h0, TOP, 4'hF, '0);
        check(36'({l_mb, r_mb}), 36'h2);
        check(l_bus, 36'h0000000A5);
        port_host_r_i.access(1'h0, 1'h1, 1'h0, TOP - 15'h1, 4'hF, '0);
        check(36'(r_mb), 36'h1);
        check(r_bus, 36'h5A5A5A5A5);
    endtask
    task automatic t_init();
        port_host_r_i.access(1'h0, 1'h1, 1'h1, TOP, 4'hF, '0);
        port_host_l_i.access(1'h0, 1'h1, 1'h1, TOP - 15'h1, 4'hF, '0);
        master_init_n = 1'h0;
        repeat (4) @(posedge clk);
        #1;
        check(36'({l_mb, r_mb, l_cw, r_cw}), 36'hF);
        master_init_n = 1'h1;
        repeat (4) @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end
    initial begin
        #20000;
        mismatches++;
        conclude();
    end
    initial begin
        rst = 1'h1;
        master_init_n = 1'h1;
        repeat (8) @(posedge clk);
        #1 rst = 1'h0;
        t_lanes();
        t_mail();
        t_init();
        conclude();
    end
endmodule // test_dual_port_mailbox_ram
`default_nettype wire
